// File: inc/twm_pkg.sv
// shared constants and types for the two-wire memory slave and its bus master
package twm_pkg;
	// device identity on the wire
	localparam logic [3:0] CTRL_CODE = 4'ha;
	localparam logic [7:0] AUX_ADDR = 8'ha0;
	localparam logic [7:0] MAIN_ADDR_RST = 8'ha2;
	// main-space byte offsets
	localparam logic [7:0] TEMP_HI_OFF = 8'h60;
	localparam logic [7:0] TEMP_LO_OFF = 8'h61;
	localparam logic [7:0] READY_OFF = 8'h6e;
	localparam logic [7:0] ALARM_OFF = 8'h70;
	localparam logic [7:0] CFG_OFF = 8'h89;
	localparam logic [7:0] DEVADR_OFF = 8'h8c;
	localparam logic [7:0] VOL_LO = 8'h60;
	localparam logic [7:0] VOL_HI = 8'h7f;
	localparam logic [7:0] MEM_RST = 8'hff;
	// field positions and reset values
	localparam int READY_BIT = 0;
	localparam int ALARM_BIT = 4;
	localparam int CFG_MLOCK = 0;
	localparam int CFG_ALOCK = 1;
	localparam int CFG_SINGLE = 2;
	localparam int CFG_NVMADR = 3;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam int PAGE_BYTES = 8;
	// timing: times in their own unit, counts derived from the clock rate
	localparam int CLK_MHZ = 100;
	localparam int NVM_WRITE_MS = 10;
	localparam int FRAME_MS = 20;
	localparam int NVM_WRITE_CYC = NVM_WRITE_MS * 1000 * CLK_MHZ;
	localparam int FRAME_CYC = FRAME_MS * 1000 * CLK_MHZ;
	// controller register map
	localparam logic [7:0] CMD_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] DIV_OFF = 8'h08;
	localparam logic [15:0] DIV_RST = 16'h00fa;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// slave protocol states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_MADR = 3'b010, S_WDAT = 3'b011,
		S_ACK = 3'b100, S_RDAT = 3'b101, S_RACK = 3'b110
	} slv_state_e;
	// controller operations and the items they are built from
	typedef enum logic [1:0] {
		OP_WRITE = 2'b00, OP_RAND_RD = 2'b01, OP_CUR_RD = 2'b10, OP_POLL = 2'b11
	} op_e;
	typedef enum logic [2:0] {
		I_START = 3'b000, I_DEVW = 3'b001, I_DEVR = 3'b010, I_MADR = 3'b011,
		I_WDAT = 3'b100, I_RX = 3'b101, I_STOP = 3'b110, I_END = 3'b111
	} item_e;
endpackage

// File: inc/twm_if.sv
// open-drain two-wire link between the bus master and the memory slave
`timescale 1ns/100ps
`default_nettype none
interface twm_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// pull-up resolution: any enabled low driver wins
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// File: src/mem_slave.sv
// two-wire protected memory slave with page writes and timed commit
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - aux and main writes gated by lock bits and pin
// - lock bits writable only through main address
// - main lock plus high pin refuses main writes
// - main bytes 60h-7Fh always writable
// - single-device mode: aux lock alone guards lower table
// - conversions store result at 60h/61h per frame
// - not-ready flag clears at first conversion, sets on dip
// - default address A2h and aux A0h before recall
// - supply-low alarm reads 1 until first conversion or a write clearing bit 4 at 70h
// - SDA changes with SCL low; START/STOP decoded
// - standby after power-on, STOP, internal work done
// - acknowledge by pulling SDA low on ninth clock
// - address byte MSB first, match main or aux
// - write mode only for unprotected space
// - byte write then STOP starts timed nvm write
// - eight-byte pages, up to eight bytes per write
// - write without STOP is discarded
// - write address wraps within page, last eight kept
// - no acknowledge while internal write runs
// - address register keeps last address plus one
// - random read is dummy write then repeated START
// - sequential read while acked, wraps FFh to 00h
// - acknowledge only with control code 1010
module mem_slave
	import twm_pkg::*;
#(
	parameter int NVM_CYCLES = NVM_WRITE_CYC,
	parameter int FRAME_CYCLES = FRAME_CYC
) (
	// clock, reset, freeze
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	// two-wire link
	twm_if.dev BUS,
	// board and analog side
	input wire logic WRITE_LOCK_PIN,
	input wire logic ANALOG_OK,
	input wire logic [15:0] TEMP_VALUE,
	input wire logic SUPPLY_LOW,
	// status
	output logic STANDBY,
	output logic NVM_BUSY
);
	if (NVM_CYCLES < 1 || FRAME_CYCLES < 2) begin
		$error("mem_slave: timing counts too small");
	end
	// all slave state except the memory array in one record
	typedef struct packed {
		logic [1:0] scl_s, sda_s, wp_s, aok_s;
		logic scl_p, sda_p, aux, drv, cm, recalled, not_ready, vcc_lo;
		slv_state_e st, after;
		logic [3:0] cnt;
		logic [7:0] sh, ptr, pval, cfg, dev_addr;
		logic [7:0][7:0] pbuf;
		logic [15:0] temp;
		logic [31:0] nvm_cnt, frm_cnt;
	} dev_s;
	dev_s r, n;
	logic [7:0] mem [0:511];
	logic [7:0] memq, rdb, main_addr;
	logic aux_en, scl, sda, rise, fall, start, stop, hit_main, hit_aux;

	// write permission of one byte
	function automatic logic wr_ok(input logic aux, input logic [7:0] a,
		input logic [7:0] cfg, input logic pin);
		if (!aux && a >= VOL_LO && a <= VOL_HI) begin
			return 1'b1;
		end else if (aux) begin
			return !(cfg[CFG_ALOCK] && pin);
		end else if (cfg[CFG_SINGLE] && a < VOL_LO) begin
			return !cfg[CFG_ALOCK];
		end else begin
			return !(cfg[CFG_MLOCK] && pin);
		end
	endfunction

	assign memq = mem[{r.aux, r.ptr}];
	assign scl = r.scl_s[1];
	assign sda = r.sda_s[1];
	assign rise = scl && !r.scl_p;
	assign fall = !scl && r.scl_p;
	assign start = scl && r.scl_p && !sda && r.sda_p;
	assign stop = scl && r.scl_p && sda && !r.sda_p;
	// fixed default until the stored address is recalled
	assign main_addr = (r.cfg[CFG_NVMADR] && r.recalled) ? r.dev_addr : MAIN_ADDR_RST;
	assign aux_en = !r.cfg[CFG_SINGLE] || !r.recalled;
	assign hit_main = r.sh[7:4] == CTRL_CODE && r.sh[7:1] == main_addr[7:1];
	assign hit_aux = aux_en && r.sh[7:4] == CTRL_CODE && r.sh[7:1] == AUX_ADDR[7:1];

	// overlay live status bytes on the main space
	always_comb begin
		rdb = memq;
		if (!r.aux) begin
			if (r.ptr == TEMP_HI_OFF) begin
				rdb = r.temp[15:8];
			end else if (r.ptr == TEMP_LO_OFF) begin
				rdb = r.temp[7:0];
			end else if (r.ptr == READY_OFF) begin
				rdb[READY_BIT] = r.not_ready;
			end else if (r.ptr == ALARM_OFF) begin
				rdb[ALARM_BIT] = r.vcc_lo;
			end else if (r.ptr == CFG_OFF) begin
				rdb = r.cfg;
			end else if (r.ptr == DEVADR_OFF) begin
				rdb = r.dev_addr;
			end
		end
	end

	// next-state logic for the whole slave
	always_comb begin
		logic [7:0] a;
		a = 8'h00;
		n = r;
		n.cm = 1'b0;
		n.scl_s = {r.scl_s[0], BUS.scl};
		n.sda_s = {r.sda_s[0], BUS.sda};
		n.wp_s = {r.wp_s[0], WRITE_LOCK_PIN};
		n.aok_s = {r.aok_s[0], ANALOG_OK};
		n.scl_p = r.scl_s[1];
		n.sda_p = r.sda_s[1];
		if (r.nvm_cnt != 32'h0) begin
			n.nvm_cnt = r.nvm_cnt - 32'h1;
		end
		// commit the page buffer one cycle after STOP
		if (r.cm) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				a = {r.ptr[7:3], 3'(i)};
				if (r.pval[i] && !r.aux) begin
					if (a == CFG_OFF) begin
						n.cfg = r.pbuf[i];
					end else if (a == DEVADR_OFF) begin
						n.dev_addr = r.pbuf[i];
					end else if (a == ALARM_OFF && !r.pbuf[i][ALARM_BIT]) begin
						n.vcc_lo = 1'b0;
					end
				end
			end
			n.pval = 8'h00;
			n.nvm_cnt = 32'(NVM_CYCLES);
		end
		// power state; recall holds until reset
		if (r.aok_s[1]) begin
			n.recalled = 1'b1;
		end else begin
			n.not_ready = 1'b1;
		end
		// conversion frames pause during any access or nvm write
		if (r.st == S_IDLE && r.nvm_cnt == 32'h0 && !r.cm) begin
			if (r.frm_cnt >= 32'(FRAME_CYCLES - 1)) begin
				n.frm_cnt = 32'h0;
				if (r.aok_s[1]) begin
					n.temp = TEMP_VALUE;
					n.vcc_lo = SUPPLY_LOW;
					n.not_ready = 1'b0;
				end
			end else begin
				n.frm_cnt = r.frm_cnt + 32'h1;
			end
		end
		// bus protocol
		if (stop) begin
			n.cm = |r.pval;
			n.st = S_IDLE;
			n.drv = 1'b0;
		end else if (start) begin
			n.pval = 8'h00;
			n.drv = 1'b0;
			n.cnt = 4'h0;
			n.st = (r.nvm_cnt != 32'h0 || r.cm) ? S_IDLE : S_ADDR;
		end else begin
			case (r.st)
				S_ADDR, S_MADR, S_WDAT: begin
					if (rise && r.cnt < 4'h8) begin
						n.sh = {r.sh[6:0], sda};
						n.cnt = r.cnt + 4'h1;
					end else if (fall && r.cnt == 4'h8) begin
						n.drv = 1'b1;
						n.st = S_ACK;
						if (r.st == S_ADDR) begin
							n.aux = hit_aux && !hit_main;
							n.after = r.sh[0] ? S_RDAT : S_MADR;
							if (!hit_main && !hit_aux) begin
								n.drv = 1'b0;
								n.st = S_IDLE;
							end
						end else if (r.st == S_MADR) begin
							n.ptr = r.sh;
							n.after = S_WDAT;
						end else begin
							n.pbuf[r.ptr[2:0]] = r.sh;
							n.pval[r.ptr[2:0]] = wr_ok(r.aux, r.ptr, r.cfg, r.wp_s[1]);
							n.ptr = {r.ptr[7:3], r.ptr[2:0] + 3'h1};
							n.after = S_WDAT;
						end
					end
				end
				S_ACK: begin
					if (fall) begin
						n.drv = 1'b0;
						n.cnt = 4'h0;
						n.st = r.after;
						if (r.after == S_RDAT) begin
							n.drv = !rdb[7];
							n.sh = {rdb[6:0], 1'b0};
							n.cnt = 4'h1;
							n.ptr = r.ptr + 8'h01;
						end
					end
				end
				S_RDAT: begin
					if (fall && r.cnt < 4'h8) begin
						n.drv = !r.sh[7];
						n.sh = {r.sh[6:0], 1'b0};
						n.cnt = r.cnt + 4'h1;
					end else if (fall) begin
						n.drv = 1'b0;
						n.st = S_RACK;
					end
				end
				S_RACK: begin
					if (rise) begin
						n.after = S_RDAT;
						n.st = sda ? S_IDLE : S_ACK;
					end
				end
				default: begin
					n.st = S_IDLE;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			r <= '0;
			r.scl_s <= 2'h3;
			r.sda_s <= 2'h3;
			r.scl_p <= 1'b1;
			r.sda_p <= 1'b1;
			r.st <= S_IDLE;
			r.cfg <= CFG_RST;
			r.dev_addr <= MAIN_ADDR_RST;
			r.not_ready <= 1'b1;
			r.vcc_lo <= 1'b1;
		end else if (CE) begin
			r <= n;
		end
	end

	// memory array; protected bytes never reach it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 512; i++) begin
				mem[i] <= MEM_RST;
			end
		end else if (CE && r.cm) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (r.pval[i]) begin
					mem[{r.aux, r.ptr[7:3], 3'(i)}] <= r.pbuf[i];
				end
			end
		end
	end

	assign BUS.dev_sda_o = 1'b0;
	assign BUS.dev_sda_oe = r.drv;
	assign STANDBY = r.st == S_IDLE && r.nvm_cnt == 32'h0 && !r.cm;
	assign NVM_BUSY = r.nvm_cnt != 32'h0;
endmodule
`default_nettype wire

// File: src/bus_master.sv
// two-wire bus master driven from software over an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module bus_master
	import twm_pkg::*;
(
	// clock, reset, freeze
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	// two-wire link
	twm_if.host BUS,
	// AXI4-Lite write channels
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read channels
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] cmd;
		logic [15:0] div;
		logic busy;
		logic nack;
		logic [7:0] rx;
		logic [3:0] k;
		logic [1:0] q;
		logic [3:0] bitn;
		logic [1:0] ab;
		logic [15:0] tick;
		logic scl_l;
		logic sda_l;
		logic [1:0] sda_s;
	} mst_s;

	mst_s r;
	mst_s n;
	item_e it;
	logic [7:0] d;

	// byte-lane merge under the write strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// item sequence of each operation
	function automatic item_e item(input logic [1:0] op, input logic [3:0] k);
		item_e s [0:7];
		case (op)
			OP_WRITE: s = '{I_START, I_DEVW, I_MADR, I_WDAT, I_STOP, I_END, I_END, I_END};
			OP_RAND_RD: s = '{I_START, I_DEVW, I_MADR, I_START, I_DEVR, I_RX, I_STOP, I_END};
			OP_CUR_RD: s = '{I_START, I_DEVR, I_RX, I_STOP, I_END, I_END, I_END, I_END};
			default: s = '{I_START, I_DEVW, I_STOP, I_END, I_END, I_END, I_END, I_END};
		endcase
		return s[k[2:0]];
	endfunction

	// an unanswered byte diverts to STOP, then ends
	always_comb begin
		if (r.ab == 2'h1) begin
			it = I_STOP;
		end else if (r.ab == 2'h2) begin
			it = I_END;
		end else begin
			it = item(r.cmd[1:0], r.k);
		end
		case (it)
			I_DEVW: d = {r.cmd[31:25], 1'b0};
			I_DEVR: d = {r.cmd[31:25], 1'b1};
			I_MADR: d = r.cmd[15:8];
			I_WDAT: d = r.cmd[23:16];
			default: d = 8'hff;
		endcase
	end

	// next-state logic: register slave and bit sequencer
	always_comb begin
		n = r;
		n.sda_s = {r.sda_s[0], BUS.sda};
		if (AWVALID && AWREADY) begin
			n.aw_got = 1'b1;
			n.awaddr = AWADDR;
		end
		if (WVALID && WREADY) begin
			n.w_got = 1'b1;
			n.wdata = WDATA;
			n.wstrb = WSTRB;
		end
		if (r.bvalid && BREADY) begin
			n.bvalid = 1'b0;
		end
		if (r.rvalid && RREADY) begin
			n.rvalid = 1'b0;
		end
		if (ARVALID && ARREADY) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			if (ARADDR == CMD_OFF) begin
				n.rdata = r.cmd;
			end else if (ARADDR == STAT_OFF) begin
				n.rdata = {16'h0, r.rx, 6'h0, r.nack, r.busy};
			end else if (ARADDR == DIV_OFF) begin
				n.rdata = {16'h0, r.div};
			end else begin
				n.rdata = 32'h0;
				n.rresp = RESP_SLVERR;
			end
		end
		// both halves of a write are in: act and answer
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			if (r.awaddr == CMD_OFF) begin
				// a command written while busy is dropped; status shows why
				if (!r.busy) begin
					n.cmd = merge(r.cmd, r.wdata, r.wstrb);
					n.busy = 1'b1;
					n.nack = 1'b0;
					n.k = 4'h0;
					n.q = 2'h0;
					n.bitn = 4'h0;
					n.ab = 2'h0;
					n.tick = 16'h0;
				end
			end else if (r.awaddr == DIV_OFF) begin
				n.div = 16'(merge({16'h0, r.div}, r.wdata, r.wstrb));
			end else if (r.awaddr != STAT_OFF) begin
				n.bresp = RESP_SLVERR;
			end
		end
		// quarter-bit sequencer; SDA moves while SCL is high only in START and STOP
		if (r.busy) begin
			if (r.tick + 16'h1 < r.div) begin
				n.tick = r.tick + 16'h1;
			end else begin
				n.tick = 16'h0;
				n.q = r.q + 2'h1;
				case (it)
					I_START: begin
						if (r.q == 2'h0) n.sda_l = 1'b1;
						if (r.q == 2'h1) n.scl_l = 1'b1;
						if (r.q == 2'h2) n.sda_l = 1'b0;
						if (r.q == 2'h3) n.scl_l = 1'b0;
						if (r.q == 2'h3) n.k = r.k + 4'h1;
					end
					I_STOP: begin
						if (r.q == 2'h0) n.sda_l = 1'b0;
						if (r.q == 2'h1) n.scl_l = 1'b1;
						if (r.q == 2'h2) n.sda_l = 1'b1;
						if (r.q == 2'h3 && r.ab == 2'h1) n.ab = 2'h2;
						if (r.q == 2'h3 && r.ab != 2'h1) n.k = r.k + 4'h1;
					end
					I_END: begin
						n.busy = 1'b0;
					end
					default: begin
						if (r.q == 2'h0) begin
							// receive bits and the closing NACK leave SDA released
							n.sda_l = (it == I_RX || r.bitn == 4'h8) ? 1'b1 : d[3'h7 - r.bitn[2:0]];
						end
						if (r.q == 2'h1) n.scl_l = 1'b1;
						if (r.q == 2'h2) begin
							if (it == I_RX && r.bitn < 4'h8) n.rx = {r.rx[6:0], r.sda_s[1]};
							if (it != I_RX && r.bitn == 4'h8 && r.sda_s[1]) begin
								n.nack = 1'b1;
								// pending: this clock must fall before the diverted STOP
								n.ab = 2'h3;
							end
						end
						if (r.q == 2'h3) begin
							n.scl_l = 1'b0;
							n.bitn = (r.bitn == 4'h8) ? 4'h0 : r.bitn + 4'h1;
							if (r.bitn == 4'h8 && r.ab == 2'h0) n.k = r.k + 4'h1;
							if (r.bitn == 4'h8 && r.ab == 2'h3) n.ab = 2'h1;
						end
					end
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			r <= '0;
			r.div <= DIV_RST;
			r.scl_l <= 1'b1;
			r.sda_l <= 1'b1;
			r.sda_s <= 2'h3;
		end else if (CE) begin
			r <= n;
		end
	end

	// handshake readies come straight from state
	assign AWREADY = !r.aw_got && !r.bvalid;
	assign WREADY = !r.w_got && !r.bvalid;
	assign ARREADY = !r.rvalid;
	assign BVALID = r.bvalid;
	assign BRESP = r.bresp;
	assign RVALID = r.rvalid;
	assign RDATA = r.rdata;
	assign RRESP = r.rresp;
	assign BUS.host_scl_o = 1'b0;
	assign BUS.host_scl_oe = !r.scl_l;
	assign BUS.host_sda_o = 1'b0;
	assign BUS.host_sda_oe = !r.sda_l;
endmodule
`default_nettype wire

// File: tb/twm_asserts.sv
// protocol assertions on the two-wire link between master and memory slave
`timescale 1ns/100ps
`default_nettype none
module twm_asserts #(
	parameter int NVM_CYCLES = 1000
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// link signals
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe,
	// slave status
	input wire logic STANDBY,
	input wire logic NVM_BUSY
);
	int busy_len;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// length of the running nvm write, a plain counter keeps the check cheap
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N)
			busy_len <= 0;
		else
			busy_len <= NVM_BUSY ? busy_len + 1 : 0;
	end
	a_dev_low_scl: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
		else $error("slave data moved while clock high");
	a_busy_no_ack: assert property (NVM_BUSY |-> !dev_sda_oe)
		else $error("slave answered during nvm write");
	a_busy_not_idle: assert property (NVM_BUSY |-> !STANDBY)
		else $error("standby during nvm write");
	a_idle_released: assert property (STANDBY |-> !dev_sda_oe)
		else $error("slave drives data in standby");
	a_ack_stands: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
		else $error("slave low bit too short");
	a_busy_span: assert property ($fell(NVM_BUSY) |->
		busy_len >= NVM_CYCLES - 2 && busy_len <= NVM_CYCLES + 1)
		else $error("nvm write length wrong");
	a_commit_idle: assert property ($rose(NVM_BUSY) |-> $past(scl) && $past(sda))
		else $error("nvm write began without stop");
	a_stop_standby: assert property (scl && $rose(sda) |-> ##[1:12] (STANDBY || NVM_BUSY))
		else $error("no standby after stop");
	// main scenarios reached
	c_write_commit: cover property ($rose(NVM_BUSY));
	c_slave_ack: cover property ($rose(dev_sda_oe) && !NVM_BUSY);
	c_start_seen: cover property (scl && $fell(sda));
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench: bus master and memory slave joined over the link
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import twm_pkg::*;
;
	localparam int NVM_N = 1000;
	localparam int FRAME_N = 300;
	localparam logic [6:0] MAIN7 = MAIN_ADDR_RST[7:1];
	localparam logic [6:0] AUX7 = AUX_ADDR[7:1];
	logic clk_sys, rst_n, lock_pin, analog_ok, supply_low, standby, nvm_busy;
	logic [15:0] temp_value;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	int num_errors, n_compared, scl_rises;
	twm_if link();
	mem_slave #(.NVM_CYCLES(NVM_N), .FRAME_CYCLES(FRAME_N)) i_mem_slave (.CLK_SYS(clk_sys),
		.RST_N(rst_n), .CE(1'b1), .BUS(link.dev), .WRITE_LOCK_PIN(lock_pin),
		.ANALOG_OK(analog_ok), .TEMP_VALUE(temp_value), .SUPPLY_LOW(supply_low),
		.STANDBY(standby), .NVM_BUSY(nvm_busy));
	bus_master i_bus_master (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(1'b1), .BUS(link.host),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
	twm_asserts #(.NVM_CYCLES(NVM_N)) i_twm_asserts (.CLK_SYS(clk_sys), .RST_N(rst_n),
		.scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe), .STANDBY(standby),
		.NVM_BUSY(nvm_busy));
	// 100 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// clock pulses seen on the wire
	always @(posedge link.scl) scl_rises++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// write channels; readiness is looked at mid-cycle, where it is settled
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok, b_ok;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bready && bvalid;
			r = bresp;
			@(posedge clk_sys);
			if (aw_ok)
				awvalid <= 1'b0;
			if (w_ok)
				wvalid <= 1'b0;
		end while (b_ok !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_ok, r_ok;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ar_ok = arvalid && arready;
			r_ok = rready && rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ar_ok)
				arvalid <= 1'b0;
		end while (r_ok !== 1'b1);
		rready <= 1'b0;
	endtask
	// one link operation through the command register, waits until not busy
	task automatic run_op(input logic [1:0] op, input logic [6:0] dev, input logic [7:0] ma,
		input logic [7:0] wd, output logic [31:0] st);
		logic [1:0] r;
		axi_wr(CMD_OFF, {dev, 1'b0, wd, ma, 6'h00, op}, r);
		do
			axi_rd(STAT_OFF, st, r);
		while (st[0] !== 1'b0);
	endtask
	task automatic wr_byte(input logic [6:0] dev, input logic [7:0] ma, input logic [7:0] wd);
		logic [31:0] st;
		run_op(OP_WRITE, dev, ma, wd, st);
		chk(st[1], 1'b0, "write acknowledged");
		do
			run_op(OP_POLL, dev, 8'h00, 8'h00, st);
		while (st[1] !== 1'b0);
	endtask
	task automatic rd_chk(input logic [6:0] dev, input logic [7:0] ma, input logic [7:0] m,
		input logic [7:0] exp, input string what);
		logic [31:0] st;
		run_op(OP_RAND_RD, dev, ma, 8'h00, st);
		chk(st[15:8] & m, exp, what);
	endtask
	task automatic t_registers();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(DIV_OFF, d, r);
		chk(d, {16'h0000, DIV_RST}, "divider reset");
		axi_rd(8'h0c, d, r);
		chk(r, RESP_SLVERR, "unmapped read");
		axi_wr(8'h0c, 32'h0000_0000, r);
		chk(r, RESP_SLVERR, "unmapped write");
		// shortest legal bit time keeps the run short
		axi_wr(DIV_OFF, 32'h0000_0008, r);
		chk(r, RESP_OKAY, "divider write");
		$display("test registers done");
	endtask
	task automatic t_power();
		rd_chk(MAIN7, READY_OFF, 8'h01, 8'h01, "not ready at power-up");
		rd_chk(MAIN7, ALARM_OFF, 8'h10, 8'h10, "supply alarm at power-up");
		rd_chk(AUX7, 8'h00, 8'hff, 8'hff, "aux before recall");
		@(posedge clk_sys);
		analog_ok <= 1'b1;
		repeat (2 * FRAME_N + 20) @(posedge clk_sys);
		rd_chk(MAIN7, READY_OFF, 8'h01, 8'h00, "ready after frame");
		rd_chk(MAIN7, ALARM_OFF, 8'h10, 8'h00, "alarm from conversion");
		rd_chk(MAIN7, TEMP_HI_OFF, 8'hff, temp_value[15:8], "temperature high");
		rd_chk(MAIN7, TEMP_LO_OFF, 8'hff, temp_value[7:0], "temperature low");
		@(posedge clk_sys);
		analog_ok <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rd_chk(MAIN7, READY_OFF, 8'h01, 8'h01, "not ready on dip");
		@(posedge clk_sys);
		analog_ok <= 1'b1;
		$display("test power done");
	endtask
	task automatic t_write_read();
		logic [31:0] st;
		scl_rises = 0;
		run_op(OP_WRITE, MAIN7, 8'h10, 8'h5a, st);
		chk(st[1], 1'b0, "byte write ack");
		chk(scl_rises, 28, "clock pulses in byte write");
		run_op(OP_POLL, MAIN7, 8'h00, 8'h00, st);
		chk(st[1], 1'b1, "poll during write");
		@(negedge clk_sys);
		chk(nvm_busy, 1'b1, "nvm write running");
		do
			run_op(OP_POLL, MAIN7, 8'h00, 8'h00, st);
		while (st[1] !== 1'b0);
		@(negedge clk_sys);
		chk(nvm_busy, 1'b0, "nvm write over at ack");
		chk({link.scl, link.sda}, 2'b11, "idle lines");
		chk(standby, 1'b1, "standby when idle");
		rd_chk(MAIN7, 8'h10, 8'hff, 8'h5a, "byte written");
		run_op(OP_CUR_RD, MAIN7, 8'h00, 8'h00, st);
		chk(st[15:8], 8'hff, "current address");
		wr_byte(MAIN7, 8'h00, 8'hc3);
		rd_chk(MAIN7, 8'hff, 8'hff, 8'hff, "last byte");
		run_op(OP_CUR_RD, MAIN7, 8'h00, 8'h00, st);
		chk(st[15:8], 8'hc3, "address wrap");
		run_op(OP_CUR_RD, 7'h29, 8'h00, 8'h00, st);
		chk(st[1], 1'b1, "wrong control code");
		run_op(OP_CUR_RD, 7'h57, 8'h00, 8'h00, st);
		chk(st[1], 1'b1, "wrong device address");
		$display("test write and read done");
	endtask
	task automatic t_protect();
		@(posedge clk_sys);
		lock_pin <= 1'b1;
		wr_byte(MAIN7, CFG_OFF, 8'h01);
		rd_chk(MAIN7, CFG_OFF, 8'hff, 8'h01, "lock byte");
		wr_byte(MAIN7, 8'h20, 8'h33);
		rd_chk(MAIN7, 8'h20, 8'hff, 8'hff, "locked main byte");
		wr_byte(MAIN7, 8'h65, 8'h77);
		rd_chk(MAIN7, 8'h65, 8'hff, 8'h77, "volatile byte");
		wr_byte(AUX7, CFG_OFF, 8'h00);
		rd_chk(MAIN7, CFG_OFF, 8'hff, 8'h01, "lock byte via aux");
		@(posedge clk_sys);
		lock_pin <= 1'b0;
		wr_byte(MAIN7, 8'h20, 8'h33);
		rd_chk(MAIN7, 8'h20, 8'hff, 8'h33, "unlocked main byte");
		wr_byte(MAIN7, CFG_OFF, 8'h02);
		@(posedge clk_sys);
		lock_pin <= 1'b1;
		wr_byte(AUX7, 8'h30, 8'h44);
		rd_chk(AUX7, 8'h30, 8'hff, 8'hff, "locked aux byte");
		@(posedge clk_sys);
		lock_pin <= 1'b0;
		wr_byte(MAIN7, CFG_OFF, 8'h06);
		wr_byte(MAIN7, 8'h21, 8'h11);
		rd_chk(MAIN7, 8'h21, 8'hff, 8'hff, "single mode lock");
		$display("test protect done");
	endtask
	// reset, then the scenarios in order
	initial begin
		rst_n = 1'b0;
		lock_pin = 1'b0;
		analog_ok = 1'b0;
		supply_low = 1'b0;
		temp_value = 16'h1b4c;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_registers();
		t_power();
		t_write_read();
		t_protect();
		report_and_stop();
	end
	// a hung handshake ends the run here
	initial begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		$display("wrong value at %0t: run did not finish", $time);
		report_and_stop();
	end
endmodule
`default_nettype wire
